//--- rtl/eisfe_pkg.sv
// Function
// - Device is only a bus slave; never drives the clock or starts transfers.
// - Start is data falling while clock is high.
// - Start is watched at all times except during a programming cycle.
// - Stop is data rising while clock is high; it ends communication.
// - Stop closing a write instruction launches the programming cycle.
// - Receiver captures data on each clock rising edge.
// - After eight bits, receiver pulls data low in the ninth clock.
// - Select byte is type identifier, chip-select bits, direction bit.
// - Type 1010b selects main array, 1011b identification page, others refused.
// - Chip-select bits must equal the strap pins to respond.
// - Select bit 0 is direction: 1 read, 0 write.
// - Bytes travel most significant bit first.
// - Mismatching select: release data line, standby until next start.
// - Matching select is acknowledged; a write select then expects an address byte, a read select goes to S_XMIT.
// - Address byte after an accepted select is acknowledged.
// - Main array uses all eight address bits, bit 7 most significant.
// - Identification page: bit 7 zero, bits 3..0 index; bit 7 one locks.
// - Write protect high: select and address acked, data bytes refused.
// - Data line is open drain: pulled low or released, never high.
// - Programming starts only on stop right after a data acknowledge.
// - During programming, data line released and all requests ignored.
package eisfe_pkg;

  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CS_MSB = 3;
  localparam int SEL_CS_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam int ADDR_TOP_BIT = 7;
  localparam int ID_IDX_MSB = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_STAGES = 2;

  // Programming time in microseconds and the core clock rate in MHz.
  localparam int unsigned PROGRAM_CYCLE_TIME_US = 5000;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PROG_CYCLES_DEF = PROGRAM_CYCLE_TIME_US * CLK_MHZ;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DEV = 5'h02,
    S_ADDR = 5'h04,
    S_DATA = 5'h08,
    S_XMIT = 5'h10
  } eisfe_state_type;

endpackage : eisfe_pkg

//--- rtl/eisfe_sync.sv
`timescale 1ns/1ps
module eisfe_sync import eisfe_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Foreign levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : eisfe_sync

//--- rtl/eisfe_prog_timer.sv
`timescale 1ns/1ps
module eisfe_prog_timer import eisfe_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Launch pulse in, busy level out.
  input wire logic start,
  output logic busy_q
);

  localparam logic [31:0] LAST_CNT = 32'(PROG_CYCLES - 1);

  logic [31:0] cnt_q;

  // A launch that arrives while busy is dropped; the link side cannot send one then.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (!busy_q && start) begin
      busy_q <= 1'b1;
      cnt_q <= 32'h0;
    end else if (busy_q && cnt_q == LAST_CNT) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  property p_start_busy;
    @(posedge clk) disable iff (!arst_n) (start && !busy_q) |=> busy_q && cnt_q == 32'h0;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("launch did not start cycle");

  property p_busy_end;
    @(posedge clk) disable iff (!arst_n) (busy_q && cnt_q == LAST_CNT) |=> !busy_q;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("cycle did not end at count");

  property p_busy_hold;
    @(posedge clk) disable iff (!arst_n) $fell(busy_q) |-> $past(cnt_q) == LAST_CNT;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("cycle ended early");

endmodule : eisfe_prog_timer

//--- rtl/eisfe_top.sv
`timescale 1ns/1ps
module eisfe_top import eisfe_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Link clock for the bus front end.
  input wire logic link_clk,
  // Two-wire bus pins; the clock is input only.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Static straps and protection.
  input wire logic [2:0] chip_select_straps,
  input wire logic write_protect_input,
  // Decoded request, link domain.
  output logic sel_id_page,
  output logic sel_read,
  output logic addr_valid,
  output logic [7:0] byte_addr,
  output logic [3:0] id_index,
  output logic lock_req,
  // Programming status, core domain.
  output logic prog_busy
);

  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (!arst_n);
  eisfe_state_type state_q;
  eisfe_state_type next_q;
  eisfe_state_type nxt;
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] straps_s;
  logic scl_p_q;
  logic sda_p_q;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic busy_l;
  logic wait_q;
  logic busy_any;
  logic rx_on;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic full_q;
  logic ack_q;
  logic ack_d;
  logic sda_oe_q;
  logic sda_o_q;
  logic sel_match;
  logic armed_q;
  logic launch_tgl_q;
  logic tgl_c;
  logic tgl_p_q;
  logic prog_go;
  logic busy_c;
  logic sel_id_page_q;
  logic sel_read_q;
  logic addr_valid_q;
  logic [7:0] byte_addr_q;
  logic [3:0] id_index_q;
  logic lock_req_q;

  // Pins are foreign to the link clock, so every one passes two flops.
  eisfe_sync #(.WIDTH(6)) u_pin_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d({scl_i, sda_i, write_protect_input, chip_select_straps}),
    .q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s = pins_s[3];
  assign straps_s = pins_s[2:0];

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  // The wait flag covers the crossing delay before the core reports busy.
  assign busy_any = busy_l || wait_q;
  assign rx_on = (state_q == S_DEV) || (state_q == S_ADDR) || (state_q == S_DATA);

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
    end else if (busy_any || stop_det) begin
      state_q <= S_IDLE;
    end else if (start_det) begin
      state_q <= S_DEV;
    end else if (scl_fall && ack_q) begin
      state_q <= next_q;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      full_q <= 1'b0;
    end else if (busy_any || start_det || stop_det) begin
      cnt_q <= 3'h0;
      full_q <= 1'b0;
    end else if (scl_rise && rx_on && !ack_q && !full_q) begin
      shift_q <= {shift_q[6:0], sda_s};
      cnt_q <= cnt_q + 3'h1;
      full_q <= (cnt_q == LAST_BIT);
    end else if (scl_fall && full_q) begin
      full_q <= 1'b0;
    end
  end

  assign sel_match = ((shift_q[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_MAIN) ||
                      (shift_q[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID)) &&
                     (shift_q[SEL_CS_MSB:SEL_CS_LSB] == straps_s);

  always_comb begin
    ack_d = 1'b0;
    nxt = S_IDLE;
    case (state_q)
      S_DEV: begin
        ack_d = sel_match;
        if (!sel_match) begin
          nxt = S_IDLE;
        end else if (shift_q[SEL_RW_BIT]) begin
          nxt = S_XMIT;
        end else begin
          nxt = S_ADDR;
        end
      end
      S_ADDR: begin
        ack_d = 1'b1;
        nxt = S_DATA;
      end
      S_DATA: begin
        ack_d = !wp_s;
        nxt = S_DATA;
      end
      default: nxt = S_IDLE;
    endcase
  end

  // The line is pulled low from the eighth fall to the ninth fall only.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      next_q <= S_IDLE;
    end else if (busy_any || start_det || stop_det) begin
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (scl_fall && full_q) begin
      ack_q <= 1'b1;
      sda_oe_q <= ack_d;
      next_q <= nxt;
    end else if (scl_fall && ack_q) begin
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
  end

  // The pin output stays low; only the enable moves, so the line is never driven high.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_id_page_q <= 1'b0;
      sel_read_q <= 1'b0;
      addr_valid_q <= 1'b0;
      byte_addr_q <= 8'h00;
      id_index_q <= 4'h0;
      lock_req_q <= 1'b0;
    end else if (scl_fall && full_q && ack_d && state_q == S_DEV) begin
      sel_id_page_q <= shift_q[SEL_TYPE_LSB];
      sel_read_q <= shift_q[SEL_RW_BIT];
      addr_valid_q <= 1'b0;
      lock_req_q <= 1'b0;
    end else if (scl_fall && full_q && state_q == S_ADDR) begin
      byte_addr_q <= shift_q;
      id_index_q <= shift_q[ID_IDX_MSB:0];
      lock_req_q <= sel_id_page_q && shift_q[ADDR_TOP_BIT];
      addr_valid_q <= 1'b1;
    end
  end

  // Armed only across the slot that follows an acknowledged data byte.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (busy_any || start_det || stop_det) begin
      armed_q <= 1'b0;
    end else if (scl_fall && ack_q) begin
      armed_q <= (state_q == S_DATA) && sda_oe_q;
    end else if (scl_fall) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      launch_tgl_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (stop_det && armed_q && !busy_any) begin
      launch_tgl_q <= !launch_tgl_q;
      wait_q <= 1'b1;
    end else if (busy_l) begin
      wait_q <= 1'b0;
    end
  end

  eisfe_sync #(.WIDTH(1)) u_launch_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(launch_tgl_q),
    .q(tgl_c)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_p_q <= 1'b0;
    end else begin
      tgl_p_q <= tgl_c;
    end
  end

  assign prog_go = tgl_c ^ tgl_p_q;

  eisfe_prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(prog_go),
    .busy_q(busy_c)
  );

  eisfe_sync #(.WIDTH(1)) u_busy_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d(busy_c),
    .q(busy_l)
  );

  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign sel_id_page = sel_id_page_q;
  assign sel_read = sel_read_q;
  assign addr_valid = addr_valid_q;
  assign byte_addr = byte_addr_q;
  assign id_index = id_index_q;
  assign lock_req = lock_req_q;
  assign prog_busy = busy_c;

  property p_oe_in_ack;
    sda_oe_q |-> ack_q;
  endproperty
  a_oe_in_ack: assert property (p_oe_in_ack) else $error("line pulled outside ack");
  property p_never_high;
    sda_o_q == 1'b0;
  endproperty
  a_never_high: assert property (p_never_high) else $error("data line driven high");
  property p_start;
    (start_det && !busy_any) |=> state_q == S_DEV && cnt_q == 3'h0 && !sda_oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    stop_det |=> state_q == S_IDLE && !sda_oe_q && !armed_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end transfer");
  property p_busy_quiet;
    busy_any |=> !sda_oe_q && state_q == S_IDLE;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("active while programming");
  property p_bad_type;
    (scl_fall && full_q && state_q == S_DEV &&
     shift_q[SEL_TYPE_MSB:SEL_TYPE_LSB+1] != 3'h5 && !busy_any && !start_det && !stop_det)
      |=> !sda_oe_q && next_q == S_IDLE;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("foreign type acknowledged");
  property p_cs_match;
    (scl_fall && full_q && state_q == S_DEV && !busy_any && !start_det && !stop_det)
      |=> sda_oe_q == ($past(shift_q[3:1]) == $past(straps_s) &&
                       $past(shift_q[7:5]) == 3'h5);
  endproperty
  a_cs_match: assert property (p_cs_match) else $error("chip select decode wrong");
  property p_wp;
    (scl_fall && full_q && state_q == S_DATA && wp_s) |=> !sda_oe_q;
  endproperty
  a_wp: assert property (p_wp) else $error("protected data acknowledged");
  property p_addr_ack;
    (scl_fall && full_q && state_q == S_ADDR && !busy_any && !start_det && !stop_det)
      |=> sda_oe_q && byte_addr_q == $past(shift_q);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_launch;
    (stop_det && armed_q && !busy_any) |=> launch_tgl_q != $past(launch_tgl_q) && wait_q;
  endproperty
  a_launch: assert property (p_launch) else $error("write cycle not launched");
  property p_no_launch;
    (stop_det && !armed_q) |=> $stable(launch_tgl_q);
  endproperty
  a_no_launch: assert property (p_no_launch) else $error("stray write launch");
  property p_ack_release;
    (ack_q && scl_fall && !full_q) |=> !sda_oe_q ##1 !sda_oe_q;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");
  property p_sample;
    (scl_rise && rx_on && !ack_q && !full_q && !busy_any && !start_det && !stop_det)
      |=> shift_q[0] == $past(sda_s) && shift_q[7:1] == $past(shift_q[6:0]);
  endproperty
  a_sample: assert property (p_sample) else $error("bit not sampled msb first");
  c_ack: cover property (scl_fall && full_q && ack_d && state_q == S_DEV);
  c_nack: cover property (scl_fall && full_q && !ack_d && state_q == S_DEV);
  c_launch: cover property (stop_det && armed_q && !busy_any);
  c_wp: cover property (scl_fall && full_q && state_q == S_DATA && wp_s);

endmodule : eisfe_top

//--- verification/eisfe_master_model.sv
`timescale 1ns/1ps
module eisfe_master_model #(
  parameter int QTR = 25
) (
  // Timing reference.
  input wire logic clk,
  // Bus pins; a released data line reads high through the pull-up.
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Each phase lasts a little over four link cycles, more than the three needed, so every edge is seen.
  task automatic q_wait();
    repeat (QTR) @(negedge clk);
  endtask : q_wait

  task automatic start_cond();
    sda_m = 1'b1;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_m = 1'b0;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask : start_cond

  task automatic stop_cond();
    sda_m = 1'b0;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_m = 1'b1;
    q_wait();
  endtask : stop_cond

  task automatic put_bit(input logic b, output logic seen);
    sda_m = b;
    q_wait();
    scl = 1'b1;
    q_wait();
    seen = sda_w;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask : put_bit

  task automatic put_byte(input logic [7:0] d, output logic ack, output logic clash);
    logic seen;
    clash = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], seen);
      clash = clash | (seen !== d[i]);
    end
    put_bit(1'b1, seen);
    ack = (seen === 1'b0);
  endtask : put_byte
endmodule : eisfe_master_model

//--- verification/eisfe_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
      error_cnt++; \
    end \
  end
module eisfe_top_tb_top;
  localparam int unsigned PROG = 3000;
  logic clk, link_clk, arst_n, scl, sda_m, sda_w, sda_o, sda_oe, wp;
  logic sel_id_page, sel_read, addr_valid, lock_req, prog_busy;
  logic [2:0] straps;
  logic [7:0] byte_addr;
  logic [3:0] id_index;
  int error_cnt;
  int checks_done;
  int busy_run;
  int busy_len;

  // The busy pulse often starts before the caller looks, so its length is counted here.
  always @(negedge clk) begin
    if (prog_busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  // Wired-AND of the master drive and the device pull.
  assign sda_w = sda_m & ~(sda_oe & ~sda_o);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #24 link_clk = ~link_clk;
  end

  eisfe_top #(.PROG_CYCLES(PROG)) eisfe_top_i (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_straps(straps),
    .write_protect_input(wp), .sel_id_page(sel_id_page), .sel_read(sel_read),
    .addr_valid(addr_valid), .byte_addr(byte_addr), .id_index(id_index),
    .lock_req(lock_req), .prog_busy(prog_busy)
  );
  eisfe_master_model eisfe_master_model_i (
    .clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w)
  );

  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic timeout_hit();
    $display("ERROR wait_bound expected %h seen %h", 1'b1, 1'b0);
    error_cnt++;
    finish_test();
  endtask : timeout_hit

  task automatic fs();
    eisfe_master_model_i.start_cond();
  endtask : fs

  task automatic fp();
    eisfe_master_model_i.stop_cond();
  endtask : fp

  task automatic xb(input logic [7:0] d, input logic exp);
    logic ack;
    logic clash;
    eisfe_master_model_i.put_byte(d, ack, clash);
    `CHK("ack", exp, ack)
    `CHK("bit_clash", 1'b0, clash)
    `CHK("sda_o", 1'b0, sda_o)
  endtask : xb

  // A missing launch must stay missing for the whole window.
  task automatic chk_busy(input logic exp);
    int w;
    int n;
    w = 0;
    n = 0;
    while (prog_busy !== 1'b1 && w < 300) begin
      @(negedge clk);
      w++;
    end
    `CHK("busy_start", exp, prog_busy)
    if (exp) begin
      while (prog_busy === 1'b1 && n < 2 * PROG) begin
        @(negedge clk);
        n++;
      end
      if (n >= 2 * PROG) timeout_hit();
      @(negedge clk);
      `CHK("busy_len", PROG, busy_len)
    end
  endtask : chk_busy

  initial begin
    int w;
    arst_n = 1'b0;
    wp = 1'b0;
    straps = 3'h5;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(negedge clk);
    `CHK("sda_oe_rst", 1'b0, sda_oe)
    `CHK("busy_rst", 1'b0, prog_busy)
    `CHK("addr_valid_rst", 1'b0, addr_valid)
    arst_n = 1'b1;
    repeat (40) @(negedge clk);
    // Every type code with matching straps; only two answer.
    for (int t = 0; t < 16; t++) begin
      fs();
      xb({t[3:0], 3'h5, 1'b0}, (t == 10) || (t == 11));
      fp();
    end
    fs();
    xb(8'hA4, 1'b0);
    xb(8'h00, 1'b0);
    fs();
    xb(8'hAA, 1'b1);
    xb(8'hC5, 1'b1);
    `CHK("byte_addr", 8'hC5, byte_addr)
    `CHK("addr_valid", 1'b1, addr_valid)
    `CHK("sel_read", 1'b0, sel_read)
    `CHK("sel_id_page", 1'b0, sel_id_page)
    fp();
    chk_busy(1'b0);
    wp = 1'b1;
    fs();
    xb(8'hAA, 1'b1);
    xb(8'h10, 1'b1);
    xb(8'h5A, 1'b0);
    fp();
    chk_busy(1'b0);
    wp = 1'b0;
    fs();
    xb(8'hAA, 1'b1);
    xb(8'h10, 1'b1);
    xb(8'h5A, 1'b1);
    fp();
    chk_busy(1'b1);
    // Poll while programming runs, then again once it is over.
    fs();
    xb(8'hAA, 1'b1);
    xb(8'h22, 1'b1);
    xb(8'h33, 1'b1);
    fp();
    fs();
    xb(8'hAA, 1'b0);
    fp();
    w = 0;
    while (prog_busy === 1'b1 && w < 2 * PROG) begin
      @(negedge clk);
      w++;
    end
    if (w >= 2 * PROG) timeout_hit();
    repeat (40) @(negedge clk);
    fs();
    xb(8'hAA, 1'b1);
    fs();
    xb(8'hBA, 1'b1);
    xb(8'h85, 1'b1);
    `CHK("lock_req", 1'b1, lock_req)
    `CHK("sel_id_page", 1'b1, sel_id_page)
    fs();
    xb(8'hBA, 1'b1);
    xb(8'h3A, 1'b1);
    `CHK("id_index", 4'hA, id_index)
    `CHK("lock_req", 1'b0, lock_req)
    fs();
    xb(8'hBB, 1'b1);
    `CHK("sel_read", 1'b1, sel_read)
    `CHK("addr_valid", 1'b0, addr_valid)
    fp();
    chk_busy(1'b0);
    finish_test();
  end
endmodule : eisfe_top_tb_top
